// *** rtl/usbrd_consts.svh ***
`ifndef USBRD_CONSTS_SVH
`define USBRD_CONSTS_SVH

// ****************************************
// Clock
// ****************************************
`define USBRD_CLK_PERIOD_NS 10

// ****************************************
// Timing, in nanoseconds
// ****************************************
// Spacing between two far-end receiver probes
`define USBRD_DET_PERIOD_NS 100000
// Probe pulse held before the result is sampled
`define USBRD_DET_SETTLE_NS 1000
// Quiet time in U0 before the low-power state is entered
`define USBRD_IDLE_NS 10000

// ****************************************
// Register offsets
// ****************************************
`define USBRD_CTRL_OFS 12'h000
`define USBRD_STATUS_OFS 12'h004
`define USBRD_STRAP_OFS 12'h008

// ****************************************
// Control fields and reset value
// ****************************************
`define USBRD_CTRL_AUTO_LFPS_BIT 0
`define USBRD_CTRL_IDLE_EN_BIT 1
`define USBRD_CTRL_RESET 2'h3

// ****************************************
// Status fields
// ****************************************
`define USBRD_STAT_STATE_LSB 0
`define USBRD_STAT_FOUND_LSB 4
`define USBRD_STAT_TERM_BIT 6
`define USBRD_STAT_LFPS_LSB 7
`define USBRD_STAT_ACT_LSB 9

// ****************************************
// Strap readback fields, channel two at +8
// ****************************************
`define USBRD_STRAP_GAIN_LSB 0
`define USBRD_STRAP_SWING_BIT 2
`define USBRD_STRAP_EMPH_LSB 3
`define USBRD_STRAP_CH2_SHIFT 8

`endif

// *** rtl/usbrd_pkg.sv ***
package usbrd_pkg;

  typedef enum logic [3:0] {
    USBRD_ST_SHUT = 4'h1,
    USBRD_ST_DISC = 4'h2,
    USBRD_ST_ACT  = 4'h4,
    USBRD_ST_LOWP = 4'h8
  } usbrd_state_e;

  typedef enum logic [1:0] {
    USBRD_GAIN_3DB = 2'h0,
    USBRD_GAIN_6DB = 2'h1,
    USBRD_GAIN_9DB = 2'h2
  } usbrd_gain_e;

  typedef enum logic {
    USBRD_SWING_0P9 = 1'h0,
    USBRD_SWING_1P1 = 1'h1
  } usbrd_swing_e;

  typedef enum logic [1:0] {
    USBRD_EMPH_0DB   = 2'h0,
    USBRD_EMPH_3P5DB = 2'h1,
    USBRD_EMPH_6P2DB = 2'h2
  } usbrd_emph_e;

endpackage

// *** rtl/usbrd_cfg_if.sv ***
`timescale 1ns/1ps
interface usbrd_cfg_if;
  import usbrd_pkg::*;
  usbrd_gain_e gain;
  usbrd_swing_e swing;
  usbrd_emph_e emph;
  modport dec (output gain, output swing, output emph);
  modport use_side (input gain, input swing, input emph);
endinterface

// *** rtl/usbrd_strap_dec.sv ***
`timescale 1ns/1ps
`include "usbrd_consts.svh"
module usbrd_strap_dec
  import usbrd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Synchronised strap samples: pd read under pull-down, pu under pull-up
  input wire logic gain_pd,
  input wire logic gain_pu,
  input wire logic swing_lvl,
  input wire logic emph_pd,
  input wire logic emph_pu,
  // Decoded settings
  usbrd_cfg_if.dec cfg
);

  // A floating pin follows the pull; a driven pin ignores it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.gain <= USBRD_GAIN_6DB;
    end else if (gain_pd && gain_pu) begin
      cfg.gain <= USBRD_GAIN_9DB;
    end else if (!gain_pd && !gain_pu) begin
      cfg.gain <= USBRD_GAIN_3DB;
    end else begin
      cfg.gain <= USBRD_GAIN_6DB;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.swing <= USBRD_SWING_0P9;
    end else begin
      cfg.swing <= swing_lvl ? USBRD_SWING_1P1 : USBRD_SWING_0P9;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.emph <= USBRD_EMPH_3P5DB;
    end else if (emph_pd && emph_pu) begin
      cfg.emph <= USBRD_EMPH_6P2DB;
    end else if (!emph_pd && !emph_pu) begin
      cfg.emph <= USBRD_EMPH_0DB;
    end else begin
      cfg.emph <= USBRD_EMPH_3P5DB;
    end
  end

  gain_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gain_pd && gain_pu) |=> cfg.gain == USBRD_GAIN_9DB)
    else $error("high gain strap not decoded as 9 dB");
  gain_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!gain_pd && gain_pu) ##1 (!gain_pd && gain_pu) |-> cfg.gain == USBRD_GAIN_6DB)
    else $error("floating gain strap not decoded as 6 dB");
  swing_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(swing_lvl) |=> cfg.swing == USBRD_SWING_1P1)
    else $error("high swing strap not decoded as 1.1 Vpp");
  emph_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!emph_pd && !emph_pu) |=> cfg.emph == USBRD_EMPH_0DB)
    else $error("low emphasis strap not decoded as 0 dB");

endmodule

// *** rtl/usbrd_ctrl.sv ***
`timescale 1ns/1ps
`include "usbrd_consts.svh"
module usbrd_ctrl
  import usbrd_pkg::*;
#(
  parameter int DET_PERIOD_CYC = `USBRD_DET_PERIOD_NS / `USBRD_CLK_PERIOD_NS,
  parameter int DET_SETTLE_CYC = `USBRD_DET_SETTLE_NS / `USBRD_CLK_PERIOD_NS,
  parameter int IDLE_CYC = `USBRD_IDLE_NS / `USBRD_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and analog front end, asynchronous
  input wire logic en_rxd,
  input wire logic [1:0] rx_present,
  input wire logic [1:0] ss_activity,
  input wire logic [1:0] lfps_sense,
  // Strap samples, asynchronous, index 0 is channel one
  input wire logic [1:0] rx_gain_strap_pd,
  input wire logic [1:0] rx_gain_strap_pu,
  input wire logic [1:0] tx_swing_strap,
  input wire logic [1:0] tx_emphasis_strap_pd,
  input wire logic [1:0] tx_emphasis_strap_pu,
  // Front-end controls
  output logic [1:0] rxdet_probe,
  output logic rx_term_en,
  output logic redrive_en,
  output logic [1:0] tx_deemph_off,
  output logic [3:0] power_state,
  // Decoded strap settings, channel one then two
  output logic [1:0] ch1_gain,
  output logic ch1_swing,
  output logic [1:0] ch1_emph,
  output logic [1:0] ch2_gain,
  output logic ch2_swing,
  output logic [1:0] ch2_emph
);

  localparam int SYNC_W = 17;
  localparam int CNT_W = 32;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic en_s;
  logic [1:0] found_s;
  logic [1:0] act_s;
  logic [1:0] lfps_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {tx_emphasis_strap_pu, tx_emphasis_strap_pd, tx_swing_strap, rx_gain_strap_pu,
                  rx_gain_strap_pd, lfps_sense, ss_activity, rx_present, en_rxd};
      sync2_r <= sync1_r;
    end
  end

  assign en_s = sync2_r[0];
  assign found_s = sync2_r[2:1];
  assign act_s = sync2_r[4:3];
  assign lfps_s = sync2_r[6:5];

  // ****************************************
  // Strap decoding
  // ****************************************
  usbrd_cfg_if cfg1 ();
  usbrd_cfg_if cfg2 ();

  // One decoder per channel so the two may be strapped differently
  usbrd_strap_dec u_dec1 (
    .pclk(pclk),
    .presetn(presetn),
    .gain_pd(sync2_r[7]),
    .gain_pu(sync2_r[9]),
    .swing_lvl(sync2_r[11]),
    .emph_pd(sync2_r[13]),
    .emph_pu(sync2_r[15]),
    .cfg(cfg1.dec)
  );

  usbrd_strap_dec u_dec2 (
    .pclk(pclk),
    .presetn(presetn),
    .gain_pd(sync2_r[8]),
    .gain_pu(sync2_r[10]),
    .swing_lvl(sync2_r[12]),
    .emph_pd(sync2_r[14]),
    .emph_pu(sync2_r[16]),
    .cfg(cfg2.dec)
  );

  assign ch1_gain = cfg1.gain;
  assign ch1_swing = cfg1.swing;
  assign ch1_emph = cfg1.emph;
  assign ch2_gain = cfg2.gain;
  assign ch2_swing = cfg2.swing;
  assign ch2_emph = cfg2.emph;

  // ****************************************
  // Control register
  // ****************************************
  logic [1:0] ctrl_r;
  logic wr_en;
  logic auto_lfps;
  logic idle_en;

  assign wr_en = psel && penable && pwrite && (paddr == `USBRD_CTRL_OFS);
  assign auto_lfps = ctrl_r[`USBRD_CTRL_AUTO_LFPS_BIT];
  assign idle_en = ctrl_r[`USBRD_CTRL_IDLE_EN_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `USBRD_CTRL_RESET;
    end else if (wr_en) begin
      ctrl_r <= pwdata[1:0];
    end
  end

  // ****************************************
  // Receiver detection timer
  // ****************************************
  usbrd_state_e state_r;
  usbrd_state_e state_nxt;
  logic probing;
  logic [CNT_W-1:0] det_cnt_r;
  logic probe_r;
  logic det_done;

  // Probing runs only where no link is confirmed or it may have gone away
  assign probing = en_s && (state_r == USBRD_ST_DISC || state_r == USBRD_ST_LOWP);
  assign det_done = probe_r && (det_cnt_r == CNT_W'(DET_SETTLE_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_cnt_r <= '0;
      probe_r <= 1'b0;
    end else if (!probing) begin
      det_cnt_r <= '0;
      probe_r <= 1'b0;
    end else if (det_done) begin
      det_cnt_r <= '0;
      probe_r <= 1'b0;
    end else if (!probe_r && det_cnt_r == CNT_W'(DET_PERIOD_CYC - 1)) begin
      det_cnt_r <= '0;
      probe_r <= 1'b1;
    end else begin
      det_cnt_r <= det_cnt_r + CNT_W'(1);
    end
  end

  assign rxdet_probe = {probe_r, probe_r};

  // ****************************************
  // U0 idle timer
  // ****************************************
  logic [CNT_W-1:0] idle_cnt_r;
  logic idle_done;

  assign idle_done = idle_en && (idle_cnt_r == CNT_W'(IDLE_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_r <= '0;
    end else if (state_r != USBRD_ST_ACT || (|act_s) || idle_done) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r != CNT_W'(IDLE_CYC - 1)) begin
      idle_cnt_r <= idle_cnt_r + CNT_W'(1);
    end
  end

  // ****************************************
  // Power state machine
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    if (!en_s) begin
      state_nxt = USBRD_ST_SHUT;
    end else begin
      unique case (state_r)
        USBRD_ST_SHUT: begin
          state_nxt = USBRD_ST_DISC;
        end
        USBRD_ST_DISC: begin
          if (det_done && found_s == 2'h3) begin
            state_nxt = USBRD_ST_ACT;
          end
        end
        USBRD_ST_ACT: begin
          if (idle_done && !(|act_s)) begin
            state_nxt = USBRD_ST_LOWP;
          end
        end
        USBRD_ST_LOWP: begin
          // A lost partner takes priority over traffic seen the same cycle
          if (det_done && found_s != 2'h3) begin
            state_nxt = USBRD_ST_DISC;
          end else if (|act_s) begin
            state_nxt = USBRD_ST_ACT;
          end
        end
        default: begin
          state_nxt = USBRD_ST_SHUT;
        end
      endcase
    end
  end

  // Reset lands in shutdown; a high enable moves on to disconnect next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= USBRD_ST_SHUT;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign power_state = state_r;

  // ****************************************
  // Termination, redrive and LFPS handling
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_term_en <= 1'b0;
      redrive_en <= 1'b0;
    end else begin
      rx_term_en <= (state_nxt == USBRD_ST_ACT) || (state_nxt == USBRD_ST_LOWP);
      redrive_en <= (state_nxt == USBRD_ST_ACT);
    end
  end

  // Per channel, so one side's LFPS leaves the other's emphasis alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_deemph_off <= 2'h0;
    end else begin
      tx_deemph_off <= lfps_s & {2{auto_lfps}};
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  logic [31:0] rd_word;
  logic rd_hit;

  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    unique case (paddr)
      `USBRD_CTRL_OFS: begin
        rd_word[1:0] = ctrl_r;
      end
      `USBRD_STATUS_OFS: begin
        rd_word[`USBRD_STAT_STATE_LSB +: 4] = state_r;
        rd_word[`USBRD_STAT_FOUND_LSB +: 2] = found_s;
        rd_word[`USBRD_STAT_TERM_BIT] = rx_term_en;
        rd_word[`USBRD_STAT_LFPS_LSB +: 2] = lfps_s;
        rd_word[`USBRD_STAT_ACT_LSB +: 2] = act_s;
      end
      `USBRD_STRAP_OFS: begin
        rd_word[`USBRD_STRAP_GAIN_LSB +: 2] = cfg1.gain;
        rd_word[`USBRD_STRAP_SWING_BIT] = cfg1.swing;
        rd_word[`USBRD_STRAP_EMPH_LSB +: 2] = cfg1.emph;
        rd_word[`USBRD_STRAP_CH2_SHIFT + `USBRD_STRAP_GAIN_LSB +: 2] = cfg2.gain;
        rd_word[`USBRD_STRAP_CH2_SHIFT + `USBRD_STRAP_SWING_BIT] = cfg2.swing;
        rd_word[`USBRD_STRAP_CH2_SHIFT + `USBRD_STRAP_EMPH_LSB +: 2] = cfg2.emph;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Captured in the setup cycle so the access phase never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0 : rd_word;
      pslverr <= !rd_hit;
    end
  end

  assign pready = 1'b1;

  // ****************************************
  // Checks
  // ****************************************
  logic [CNT_W-1:0] gap_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= '0;
    end else if (!probing || probe_r) begin
      gap_r <= '0;
    end else begin
      gap_r <= gap_r + CNT_W'(1);
    end
  end

  disc_probe_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == USBRD_ST_DISC |-> gap_r <= CNT_W'(DET_PERIOD_CYC))
    else $error("no receiver probe within one period in disconnect");
  lowp_probe_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == USBRD_ST_LOWP |-> gap_r <= CNT_W'(DET_PERIOD_CYC))
    else $error("no receiver probe within one period in low power");
  term_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rx_term_en) |-> $past(det_done) && $past(found_s) == 2'h3)
    else $error("termination enabled without a detected receiver");
  both_found_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == USBRD_ST_DISC ##1 state_r == USBRD_ST_ACT |-> $past(found_s) == 2'h3)
    else $error("entered U0 without both far-end receivers");
  u0_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == USBRD_ST_ACT && en_s && (|act_s)) |=> state_r == USBRD_ST_ACT && redrive_en)
    else $error("left U0 while traffic was arriving");
  shut_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    !en_s |=> state_r == USBRD_ST_SHUT ##1 !rx_term_en)
    else $error("detect-enable low did not force shutdown");
  lfps_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lfps_s[0] && auto_lfps) |=> tx_deemph_off[0])
    else $error("de-emphasis stayed on during LFPS");
  resume_disc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == USBRD_ST_SHUT && en_s) |=> state_r == USBRD_ST_DISC ##[1:2] !rx_term_en)
    else $error("did not resume in disconnect after shutdown");

endmodule

// *** bench/usbrd_link_model.sv ***
`timescale 1ns/1ps
module usbrd_link_model (
  // Clock
  input wire logic pclk,
  // Probe from the redriver
  input wire logic [1:0] rxdet_probe,
  // Scenario controls
  input wire logic [1:0] attach,
  input wire logic [1:0] traffic,
  input wire logic [1:0] lfps,
  // Far-end answers
  output logic [1:0] rx_present,
  output logic [1:0] ss_activity,
  output logic [1:0] lfps_sense
);
  // ****************************************
  // Far-end termination
  // ****************************************
  // Outside a probe the comparator has no valid answer, so show the opposite level
  assign rx_present = (rxdet_probe & attach) | (~rxdet_probe & ~attach);
  assign ss_activity = traffic;
  assign lfps_sense = lfps;
endmodule

// *** bench/usbrd_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module usbrd_ctrl_tb_top;
  import usbrd_pkg::*;
  localparam int PER = 20;
  localparam int SET = 4;
  localparam int IDLE = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, en_rxd, rx_term_en, redrive_en, err;
  logic ch1_swing, ch2_swing;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] rx_present, ss_activity, lfps_sense, attach, traffic, lfps, rxdet_probe, tx_deemph_off;
  logic [1:0] gain_pd, gain_pu, swing, emph_pd, emph_pu, ch1_gain, ch2_gain, ch1_emph, ch2_emph;
  logic [3:0] power_state;
  int errors, tests_run, r, o;

  usbrd_ctrl #(.DET_PERIOD_CYC(PER), .DET_SETTLE_CYC(SET), .IDLE_CYC(IDLE)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .en_rxd(en_rxd), .rx_present(rx_present), .ss_activity(ss_activity), .lfps_sense(lfps_sense),
    .rx_gain_strap_pd(gain_pd), .rx_gain_strap_pu(gain_pu), .tx_swing_strap(swing),
    .tx_emphasis_strap_pd(emph_pd), .tx_emphasis_strap_pu(emph_pu), .rxdet_probe(rxdet_probe),
    .rx_term_en(rx_term_en), .redrive_en(redrive_en), .tx_deemph_off(tx_deemph_off),
    .power_state(power_state), .ch1_gain(ch1_gain), .ch1_swing(ch1_swing), .ch1_emph(ch1_emph),
    .ch2_gain(ch2_gain), .ch2_swing(ch2_swing), .ch2_emph(ch2_emph));

  usbrd_link_model partner (.pclk(pclk), .rxdet_probe(rxdet_probe), .attach(attach),
    .traffic(traffic), .lfps(lfps), .rx_present(rx_present), .ss_activity(ss_activity),
    .lfps_sense(lfps_sense));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) check("pready", 32'h1, 32'h0);
  endtask

  // Waits are bounded so a stuck state machine shows up as a mismatch, not a hang
  task automatic wait_state(input logic [3:0] exp, input int max);
    int n;
    n = 0;
    while (power_state !== exp && n < max) begin
      @(negedge pclk);
      n++;
    end
    check("power_state", {28'h0, exp}, {28'h0, power_state});
  endtask

  task automatic watch(input int cyc, input logic [3:0] st, output int rises, output int off);
    logic prev;
    prev = rxdet_probe[0];
    rises = 0;
    off = 0;
    repeat (cyc) begin
      @(negedge pclk);
      if (rxdet_probe[0] === 1'b1 && prev === 1'b0) rises++;
      if (power_state !== st) off++;
      prev = rxdet_probe[0];
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    check("state_reset", 32'h1, {28'h0, power_state});
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl_reset", 32'h3, rd);
    check("ctrl_err", 32'h0, {31'h0, err});
    apb(1'b1, 12'h00C, 32'h0);
    check("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b0, 12'h00C, 32'h0);
    check("unmapped_rd", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic t_detect();
    @(posedge pclk);
    en_rxd <= 1'b1;
    attach <= 2'h1;
    wait_state(4'h2, 8);
    watch(3 * (PER + SET) + 4, 4'h2, r, o);
    check("probe_repeat", 32'h1, {31'h0, r >= 3});
    check("disc_one_port", 32'h0, o);
    check("term_off", 32'h0, {31'h0, rx_term_en});
    @(posedge pclk);
    attach <= 2'h3;
    wait_state(4'h4, 2 * (PER + SET) + 8);
    check("term_on", 32'h1, {31'h0, rx_term_en});
    check("redrive_on", 32'h1, {31'h0, redrive_en});
    $display("test detect done");
  endtask

  task automatic t_u0();
    @(posedge pclk);
    traffic <= 2'h3;
    watch(4 * IDLE, 4'h4, r, o);
    check("u0_hold", 32'h0, o);
    apb(1'b0, 12'h004, 32'h0);
    check("status_u0", 32'h644, rd);
    @(posedge pclk);
    traffic <= 2'h0;
    wait_state(4'h8, IDLE + 10);
    watch(3 * (PER + SET), 4'h8, r, o);
    check("lowp_probe", 32'h1, {31'h0, r >= 2});
    check("lowp_hold", 32'h0, o);
    @(posedge pclk);
    traffic <= 2'h2;
    wait_state(4'h4, 10);
    @(posedge pclk);
    traffic <= 2'h0;
    wait_state(4'h8, IDLE + 10);
    @(posedge pclk);
    attach <= 2'h2;
    wait_state(4'h2, 2 * (PER + SET) + 8);
    check("redrive_off", 32'h0, {31'h0, redrive_en});
    $display("test u0 done");
  endtask

  task automatic t_lfps();
    for (int i = 1; i < 4; i++) begin
      @(posedge pclk);
      lfps <= 2'(i);
      repeat (5) @(negedge pclk);
      check("deemph_off", 32'(i), {30'h0, tx_deemph_off});
    end
    apb(1'b1, 12'h000, 32'h2);
    repeat (5) @(negedge pclk);
    check("deemph_manual", 32'h0, {30'h0, tx_deemph_off});
    apb(1'b1, 12'h000, 32'h3);
    @(posedge pclk);
    lfps <= 2'h0;
    $display("test lfps done");
  endtask

  task automatic t_strap();
    int g1, g2, e1, e2;
    logic s1;
    for (int i = 0; i < 3; i++) begin
      g1 = i;
      g2 = (i + 1) % 3;
      e1 = (i + 2) % 3;
      e2 = i;
      s1 = i[0];
      @(posedge pclk);
      gain_pd <= {g2 == 2, g1 == 2};
      gain_pu <= {g2 != 0, g1 != 0};
      emph_pd <= {e2 == 2, e1 == 2};
      emph_pu <= {e2 != 0, e1 != 0};
      swing <= {~s1, s1};
      repeat (5) @(negedge pclk);
      check("ch1_gain", 32'(g1), {30'h0, ch1_gain});
      check("ch2_gain", 32'(g2), {30'h0, ch2_gain});
      check("ch1_emph", 32'(e1), {30'h0, ch1_emph});
      check("ch2_emph", 32'(e2), {30'h0, ch2_emph});
      check("swing", {30'h0, ~s1, s1}, {30'h0, ch2_swing, ch1_swing});
      apb(1'b0, 12'h008, 32'h0);
      check("strap_reg", {2'(e2), ~s1, 2'(g2), 3'h0, 2'(e1), s1, 2'(g1)}, rd[12:0]);
    end
    $display("test strap done");
  endtask

  task automatic t_shut();
    apb(1'b1, 12'h000, 32'h1);
    @(posedge pclk);
    attach <= 2'h3;
    wait_state(4'h4, 2 * (PER + SET) + 8);
    watch(2 * IDLE, 4'h4, r, o);
    check("idle_off_hold", 32'h0, o);
    @(posedge pclk);
    en_rxd <= 1'b0;
    wait_state(4'h1, 6);
    watch(PER + SET + 4, 4'h1, r, o);
    check("shut_quiet", 32'h0, r + o + rx_term_en + redrive_en);
    @(posedge pclk);
    en_rxd <= 1'b1;
    wait_state(4'h2, 6);
    watch(PER + SET + 6, 4'h2, r, o);
    check("resume_probe", 32'h1, {31'h0, r >= 1});
    $display("test shutdown done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, en_rxd} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {attach, traffic, lfps} = 6'h0;
    {gain_pd, emph_pd, swing} = 6'h0;
    gain_pu = 2'h3;
    emph_pu = 2'h3;
    errors = 0;
    tests_run = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(negedge pclk);
    t_reset();
    t_detect();
    t_u0();
    t_lfps();
    t_strap();
    t_shut();
    give_verdict();
  end

  initial begin
    #100000;
    errors++;
    give_verdict();
  end
endmodule
